/* sld_pkg.sv */
package sld_pkg;

  // ==========================================================================
  // register map (byte addresses on the apb side)
  // ==========================================================================
  localparam logic [7:0] SLD_OFS_MODE = 8'h00;  // display_mode_register
  localparam logic [7:0] SLD_OFS_CLKC = 8'h04;  // lcd_clock_control
  localparam logic [7:0] SLD_OFS_PFN = 8'h08;   // segment_port_function
  localparam logic [7:0] SLD_OFS_RAM = 8'h40;   // first display memory word
  localparam int SLD_RAM_WORDS = 24;
  localparam logic [7:0] SLD_RAM_SPAN = 8'h60;  // 24 words of 4 bytes

  // ==========================================================================
  // field positions and reset values
  // ==========================================================================
  localparam int SLD_MODE_EN_BIT = 7;   // display_enable_bit
  localparam int SLD_MODE_AMP_BIT = 6;  // gate_amp_enable_bit
  localparam int SLD_MODE_SEL_BIT = 2;  // mode_select_bit, 1 = static
  localparam int SLD_CLKC_SRC_LSB = 2;  // source_select_lo
  localparam int SLD_CLKC_DIV_LSB = 0;  // divider_select_lo
  localparam int SLD_PFN_BITS = 6;
  localparam int SLD_PFN_FIRST_SEG = 22;  // pin_function_bit 0 shares segment 22
  localparam logic [3:0] SLD_CLKC_RST = 4'h0;
  localparam logic [5:0] SLD_PFN_RST = 6'h00;
  localparam logic [2:0] SLD_MODE_RST = 3'h0;

  // ==========================================================================
  // drive levels: 3 = top rail, 2 = two thirds, 1 = one third, 0 = ground
  // ==========================================================================
  localparam logic [1:0] SLD_LV_VSS = 2'h0;
  localparam logic [1:0] SLD_LV_THIRD = 2'h1;
  localparam logic [1:0] SLD_LV_TWO_THIRDS = 2'h2;
  localparam logic [1:0] SLD_LV_TOP = 2'h3;

  // ==========================================================================
  // counts of cycles
  // ==========================================================================
  localparam int SLD_PRE_BITS = 7;      // main clock prescaler, up to /128
  localparam int SLD_SRC_LOG_BASE = 4;  // code 01 gives 2**5 = /32
  localparam int SLD_DIV_BITS = 9;      // half period up to 2**8 source ticks
  localparam int SLD_HALF_LOG_BASE = 5; // code 00 gives /64 per full period

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic [3:0][1:0] com;   // common_line_0 .. common_line_3
    logic [23:0][1:0] seg;  // segment_out_first .. segment_out_last
  } sld_drive_s;

  typedef struct packed {
    logic [2:0] mode;       // {enable, amp, static}
    logic [3:0] clkc;       // {source[1:0], divider[1:0]}
    logic [5:0] pfn;
    logic [23:0][3:0] ram;
    logic [6:0] pre;
    logic [8:0] div;
    logic sub_q;
    logic phase;
    logic [1:0] slot;
    sld_drive_s drive;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sld_state_s;

endpackage

/* sld_lcd_drive.sv */
// What this block does
// - clock control resets to zero
// - source select: subsystem, main /32 /64 /128
// - divider select: source /64 /128 /256 /512
// - frame equals lcd clock, quarter in four-slot
// - six port function bits, reset to zero
// - 24 display bytes behave as plain ram
// - display byte top nibble reads zero
// - slot n samples bit n of each byte
// - one selects, zero deselects; byte k to segment k
// - static mode ignores display bits 1 to 3
// - commons activated in turn per mode
// - full voltage only when both lines select, or at a port pin under a top-rail common
// - alternate polarity; 1/3 bias intermediate deselect levels
// - display off drives segments deselected
// - mode select zero four-slot, one static
// - static mode commons copy common line 0
`timescale 1ns/1ns
`default_nettype none

module sld_lcd_drive (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sub_clk_i,
  output sld_pkg::sld_drive_s drive_o,
  output logic [5:0] port_sel_o,
  output logic amp_en_o,
  output logic display_en_o
);
  import sld_pkg::*;

  sld_state_s s;
  sld_state_s nxt_s;

  // ==========================================================================
  // helpers
  // ==========================================================================
  // one source tick per selected period; subsystem ticks on its rising edge
  function automatic logic src_tick(input logic [6:0] pre, input logic [1:0] sel,
                                    input logic sub_rise);
    logic [6:0] mask;
    mask = 7'h7F >> (3 - sel);
    if (sel == 2'h0) begin
      src_tick = sub_rise;
    end else begin
      src_tick = ((pre & mask) == mask);
    end
  endfunction

  // level of a common line for its select state, bias mode and phase
  function automatic logic [1:0] com_level(input logic sel, input logic bias,
                                           input logic ph);
    if (sel || !bias) begin
      com_level = ph ? SLD_LV_VSS : SLD_LV_TOP;
    end else begin
      com_level = ph ? SLD_LV_TWO_THIRDS : SLD_LV_THIRD;
    end
  endfunction

  // level of a segment line; deselect mirrors the common in static mode
  function automatic logic [1:0] seg_level(input logic on, input logic bias,
                                           input logic ph);
    if (on) begin
      seg_level = ph ? SLD_LV_TOP : SLD_LV_VSS;
    end else if (!bias) begin
      seg_level = ph ? SLD_LV_VSS : SLD_LV_TOP;
    end else begin
      seg_level = ph ? SLD_LV_THIRD : SLD_LV_TWO_THIRDS;
    end
  endfunction

  function automatic logic [1:0] abs_diff(input logic [1:0] a, input logic [1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  logic bias_mode;
  logic ram_hit;
  logic [7:0] ram_ofs;
  logic [4:0] ram_idx;
  logic tick;
  logic [8:0] half_end;
  logic [1:0] use_slot;
  logic seg_on;
  integer k;

  assign bias_mode = !s.mode[SLD_MODE_SEL_BIT - 2 + 0];
  assign ram_ofs = paddr_i - SLD_OFS_RAM;
  assign ram_hit = (paddr_i >= SLD_OFS_RAM) && (ram_ofs < SLD_RAM_SPAN) &&
                   (paddr_i[1:0] == 2'h0);
  assign ram_idx = ram_ofs[6:2];
  assign tick = src_tick(s.pre, s.clkc[SLD_CLKC_SRC_LSB +: 2],
                         sub_clk_i & ~s.sub_q);
  // half of one lcd clock period, in source ticks, minus one
  assign half_end = 9'h0FF >> (3 - s.clkc[SLD_CLKC_DIV_LSB +: 2]);
  assign use_slot = bias_mode ? s.slot : 2'h0;

  always_comb begin
    nxt_s = s;
    seg_on = 1'b0;
    // apb: one wait state, read data prepared with pready
    nxt_s.pready = 1'b0;
    nxt_s.pslverr = 1'b0;
    if (psel_i && penable_i && !s.pready) begin
      nxt_s.pready = 1'b1;
      nxt_s.prdata = 32'h0000_0000;
      if (paddr_i == SLD_OFS_MODE) begin
        nxt_s.prdata[SLD_MODE_EN_BIT] = s.mode[2];
        nxt_s.prdata[SLD_MODE_AMP_BIT] = s.mode[1];
        nxt_s.prdata[SLD_MODE_SEL_BIT] = s.mode[0];
      end else if (paddr_i == SLD_OFS_CLKC) begin
        nxt_s.prdata[3:0] = s.clkc;
      end else if (paddr_i == SLD_OFS_PFN) begin
        nxt_s.prdata[5:0] = s.pfn;
      end else if (ram_hit) begin
        nxt_s.prdata[3:0] = s.ram[ram_idx];
      end else begin
        nxt_s.pslverr = 1'b1;
      end
    end
    // writes land on the edge that completes the access
    if (psel_i && penable_i && s.pready && pwrite_i) begin
      if (paddr_i == SLD_OFS_MODE) begin
        nxt_s.mode = {pwdata_i[SLD_MODE_EN_BIT], pwdata_i[SLD_MODE_AMP_BIT],
                      pwdata_i[SLD_MODE_SEL_BIT]};
      end else if (paddr_i == SLD_OFS_CLKC) begin
        // upper nibble is not stored, so a stray one cannot change the rate
        nxt_s.clkc = pwdata_i[3:0];
      end else if (paddr_i == SLD_OFS_PFN) begin
        nxt_s.pfn = pwdata_i[5:0];
      end else if (ram_hit) begin
        nxt_s.ram[ram_idx] = pwdata_i[3:0];
      end
    end
    // clock chain: prescaler, source tick, half period, slot
    nxt_s.pre = s.pre + 7'h01;
    nxt_s.sub_q = sub_clk_i;
    if (tick) begin
      if (s.div >= half_end) begin
        nxt_s.div = 9'h000;
        nxt_s.phase = !s.phase;
        if (s.phase) begin
          // one lcd clock period per slot; static frame is one period
          nxt_s.slot = bias_mode ? (s.slot + 2'h1) : 2'h0;
        end
      end else begin
        nxt_s.div = s.div + 9'h001;
      end
    end
    // drive levels for the panel
    for (k = 0; k < 4; k++) begin
      nxt_s.drive.com[k] = com_level(!bias_mode || (use_slot == k[1:0]),
                                     bias_mode, s.phase);
    end
    for (k = 0; k < SLD_RAM_WORDS; k++) begin
      seg_on = s.mode[2] && s.ram[k][use_slot];
      nxt_s.drive.seg[k] = seg_level(seg_on, bias_mode, s.phase);
    end
    // pins handed to the port give up the segment drive
    for (k = 0; k < SLD_PFN_BITS; k++) begin
      if (s.pfn[k]) begin
        nxt_s.drive.seg[SLD_PFN_FIRST_SEG - k] = SLD_LV_VSS;
      end
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  // a system reset clears all registers, display memory included
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.mode <= SLD_MODE_RST;
      s.clkc <= SLD_CLKC_RST;
      s.pfn <= SLD_PFN_RST;
    end else begin
      s <= nxt_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign drive_o = s.drive;
  assign port_sel_o = s.pfn;
  assign amp_en_o = s.mode[1];
  assign display_en_o = s.mode[2];

  // ==========================================================================
  // assertions
  // ==========================================================================
  a_clkc_reset: assert property (@(posedge ref_clk_i) $past(srst_i) |-> s.clkc == 4'h0)
    else $error("clock control not cleared by reset");

  a_pfn_reset: assert property (@(posedge ref_clk_i) srst_i |=> port_sel_o == 6'h00)
    else $error("port function not cleared by reset");

  a_ram_nibble: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (psel_i && penable_i && !pwrite_i && ram_hit && !pready_o) |=> prdata_o[31:4] == 28'h0)
    else $error("display byte top bits not zero");

  a_off_deselect: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ($past(!s.mode[2]) && $past(!s.pfn[5]) && !$past(srst_i)) |->
      drive_o.seg[17] == seg_level(1'b0, $past(bias_mode), $past(s.phase)))
    else $error("segment not deselected while display off");

  a_static_commons: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $past(!bias_mode) && !$past(srst_i) |->
      (drive_o.com[1] == drive_o.com[0]) && (drive_o.com[2] == drive_o.com[0]) &&
      (drive_o.com[3] == drive_o.com[0]))
    else $error("static commons differ");

  a_static_slot: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !bias_mode && tick && s.phase && (s.div >= half_end) |=> s.slot == 2'h0)
    else $error("static mode left slot zero");

  a_phase_flip: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $changed(s.phase) && $past(!bias_mode) && !bias_mode |=>
      drive_o.com[0] == (2'h3 - $past(drive_o.com[0])))
    else $error("common polarity not reversed");

  a_no_two_thirds: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    abs_diff(drive_o.com[0], drive_o.seg[0]) != 2'h2)
    else $error("pixel saw a two-thirds difference");

  a_seg_select: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s.mode[2] ##1 $stable(s.mode) && $stable(s.phase) && $stable(s.slot) &&
      $stable(s.ram[0]) |->
      drive_o.seg[0] == seg_level(s.ram[0][use_slot], bias_mode, s.phase))
    else $error("segment level does not follow display bit");

  // the answer of the register bus stands for one cycle only
  a_pready_pulse: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    pready_o |=>
      !pready_o)
    else $error("pready held longer than one cycle");

  a_unmapped_err: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    pslverr_o |->
      pready_o && (prdata_o == 32'h0000_0000))
    else $error("error response without pready or with data");

  a_mode_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    psel_i && penable_i && pready_o && pwrite_i && (paddr_i == SLD_OFS_MODE) |=>
      (display_en_o == $past(pwdata_i[SLD_MODE_EN_BIT])) &&
      (s.mode[0] == $past(pwdata_i[SLD_MODE_SEL_BIT])))
    else $error("mode write did not land");

  a_port_pin_low: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    port_sel_o[0] |=>
      drive_o.seg[SLD_PFN_FIRST_SEG] == SLD_LV_VSS)
    else $error("port pin still drives a segment level");

  a_seg0_off: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $past(!s.mode[2]) && !$past(srst_i) |->
      drive_o.seg[0] == seg_level(1'b0, $past(bias_mode), $past(s.phase)))
    else $error("first segment not deselected while display off");

  // the source tick must sit on the prescaler slot of the selected division
  a_tick_div32: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (s.clkc[SLD_CLKC_SRC_LSB +: 2] == 2'h1) && tick |->
      s.pre[4:0] == 5'h1F)
    else $error("main clock source tick off its /32 slot");

  a_tick_div128: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (s.clkc[SLD_CLKC_SRC_LSB +: 2] == 2'h3) && tick |->
      s.pre == 7'h7F)
    else $error("main clock source tick off its /128 slot");

  a_tick_sub: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (s.clkc[SLD_CLKC_SRC_LSB +: 2] == 2'h0) && sub_clk_i && !s.sub_q |->
      tick)
    else $error("subsystem clock edge gave no source tick");

  a_half_count: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    tick && (s.div < half_end) |=>
      (s.div == $past(s.div) + 9'h001) && $stable(s.phase))
    else $error("half period counter skipped");

  a_idle_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !tick |=>
      $stable(s.div) && $stable(s.phase) && $stable(s.slot))
    else $error("lcd clock advanced without a source tick");

  a_slot_advance: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    bias_mode && tick && s.phase && (s.div >= half_end) |=>
      s.slot == $past(s.slot) + 2'h1)
    else $error("four-slot scan skipped a common line");

endmodule

`default_nettype wire

/* sld_dummy_unused.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* sld_panel_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// passive glass: a pixel lights on the full rail-to-rail swing
// ============================================================
module sld_panel_model (
  input wire sld_pkg::sld_drive_s drive_i,
  output logic [3:0][23:0] lit_o
);
  import sld_pkg::*;

  // any third-level difference stays dark, so bias slips show up as unlit pixels
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 24; s++) begin
        lit_o[c][s] = (drive_i.com[c] == SLD_LV_TOP && drive_i.seg[s] == SLD_LV_VSS) ||
                      (drive_i.com[c] == SLD_LV_VSS && drive_i.seg[s] == SLD_LV_TOP);
      end
    end
  end
endmodule
`default_nettype wire

/* sld_lcd_drive_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module sld_lcd_drive_tb;
  import sld_pkg::*;
  // ============================================================
  // stimulus and observed signals
  // ============================================================
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, sub_clk = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, amp_en, disp_en;
  logic [2:0] subdiv = 3'h0;
  logic [5:0] port_sel, pf;
  logic [3:0][23:0] lit;
  logic [3:0] ram [24];
  sld_drive_s drive;
  int error_cnt = 0, checks_done = 0, n, len;
  int srcs [7] = '{0, 1, 2, 3, 0, 0, 0};
  int dvs [7] = '{0, 0, 0, 0, 1, 2, 3};

  sld_lcd_drive dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sub_clk_i(sub_clk), .drive_o(drive), .port_sel_o(port_sel),
    .amp_en_o(amp_en), .display_en_o(disp_en));
  sld_panel_model panel (.drive_i(drive), .lit_o(lit));

  always #25 ref_clk_i = ~ref_clk_i;
  // slow subsystem clock: one rising edge every 8 main cycles keeps runs short
  always @(posedge ref_clk_i) begin
    subdiv <= subdiv + 3'h1;
    sub_clk <= subdiv[2];
  end

  // ============================================================
  // shared tasks
  // ============================================================
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cmp_lvl(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("mismatch pready expected 1 seen %0h", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // waits for the next change of the first common line, counting edges
  task automatic next_half(output int cnt);
    logic [1:0] c;
    c = drive.com[0];
    cnt = 0;
    while (drive.com[0] === c && cnt < 9000) begin
      @(posedge ref_clk_i);
      cnt++;
    end
  endtask

  function automatic int exp_half(input int src, input int dv);
    return (32 << dv) * ((src == 0) ? 8 : (16 << src));
  endfunction

  // first half is only a resync after a mode change
  task automatic scan(input int halves, input logic stat, input logic en);
    int h, j, k, s, ps;
    logic ph, pph, b, prt;
    logic [1:0] e;
    s = 0;
    ps = 0;
    pph = 1'b0;
    for (h = 0; h <= halves; h++) begin
      next_half(len);
      if (h == 0) continue;
      for (j = 3; j >= 0; j--) begin
        if (drive.com[j] === SLD_LV_TOP || drive.com[j] === SLD_LV_VSS) s = j;
      end
      ph = (drive.com[s] === SLD_LV_VSS);
      if (h > 1) begin
        cmp("phase", 32'(!pph), 32'(ph));
        cmp("slot", 32'(stat ? 0 : (pph ? (ps + 1) % 4 : ps)), 32'(s));
      end
      for (j = 0; j < 4; j++) begin
        e = (j == s || stat) ? (ph ? 2'h0 : 2'h3) : (ph ? 2'h2 : 2'h1);
        cmp_lvl("com", e, drive.com[j]);
      end
      for (k = 0; k < 24; k++) begin
        b = en && ram[k][stat ? 0 : s];
        prt = k >= 17 && k <= 22 && pf[22 - k];
        e = prt ? 2'h0 : b ? (ph ? 2'h3 : 2'h0) : stat ? (ph ? 2'h0 : 2'h3) : (ph ? 2'h1 : 2'h2);
        cmp_lvl("seg", e, drive.seg[k]);
        // a port pin sits at ground, so it lights under a top-rail common
        cmp("lit", 32'(prt ? !ph : b), 32'(lit[s][k]));
      end
      pph = ph;
      ps = s;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // tests
  // ============================================================
  initial begin
    n = $urandom(32'hB14A);
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    apb(1'b0, SLD_OFS_CLKC, 32'h0);
    cmp("clock control", 32'h0, rd);
    apb(1'b0, SLD_OFS_PFN, 32'h0);
    cmp("port function", 32'h0, rd);
    cmp("port select", 32'h0, 32'(port_sel));
    apb(1'b1, 8'h0C, 32'hFF);
    cmp("unmapped error", 32'h1, 32'(err));
    $display("test reset and map done");
    // top nibble written high on purpose: it must never read back
    for (int k = 0; k < 24; k++) begin
      ram[k] = 4'($urandom);
      apb(1'b1, SLD_OFS_RAM + 8'(4 * k), {24'($urandom), 4'hF, ram[k]});
    end
    for (int k = 0; k < 24; k++) begin
      apb(1'b0, SLD_OFS_RAM + 8'(4 * k), 32'h0);
      cmp("display memory", 32'(ram[k]), rd);
    end
    apb(1'b1, SLD_OFS_MODE, 32'h7F);
    apb(1'b0, SLD_OFS_MODE, 32'h0);
    cmp("mode", 32'h44, rd);
    cmp("amp enable", 32'h1, 32'(amp_en));
    // amp dropped again: its settle time is far beyond this run, so display never rides on it
    apb(1'b1, SLD_OFS_MODE, 32'h0);
    $display("test memory done");
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, SLD_OFS_CLKC, 32'((srcs[i] << 2) | dvs[i]));
      apb(1'b0, SLD_OFS_CLKC, 32'h0);
      cmp("clock control", 32'((srcs[i] << 2) | dvs[i]), rd);
      next_half(len);
      next_half(len);
      cmp("half period", 32'(exp_half(srcs[i], dvs[i])), 32'(len));
    end
    $display("test clock select done");
    apb(1'b1, SLD_OFS_CLKC, 32'h0);
    pf = 6'($urandom);
    apb(1'b1, SLD_OFS_PFN, {26'h0, pf});
    // the register output moves on the edge that ends the access
    @(posedge ref_clk_i);
    cmp("port select", 32'(pf), 32'(port_sel));
    scan(4, 1'b0, 1'b0);
    apb(1'b1, SLD_OFS_MODE, 32'h80);
    @(posedge ref_clk_i);
    cmp("display enable", 32'h1, 32'(disp_en));
    scan(9, 1'b0, 1'b1);
    apb(1'b1, SLD_OFS_MODE, 32'h84);
    scan(4, 1'b1, 1'b1);
    $display("test scan done");
    // second reset in mid-run: registers and memory must come back cleared
    apb(1'b1, SLD_OFS_MODE, 32'h0);
    apb(1'b1, SLD_OFS_CLKC, 32'h5);
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    apb(1'b0, SLD_OFS_CLKC, 32'h0);
    cmp("clock control", 32'h0, rd);
    apb(1'b0, SLD_OFS_PFN, 32'h0);
    cmp("port function", 32'h0, rd);
    apb(1'b0, SLD_OFS_RAM, 32'h0);
    cmp("display memory", 32'h0, rd);
    $display("test mid-run reset done");
    tally_and_finish();
  end

  // whole run is about 27k cycles; this bound only catches a hang
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule
`default_nettype wire
